// File: logic/vic_defines.svh
// Purpose: offsets, field positions, reset values and timing counts of the vectored interrupt controller
// Assumes: apb byte addresses, 32-bit data words, 8-bit and 16-bit registers in the low bits
// Notes:   vector of order n is base plus n times the step
`ifndef VIC_DEFINES_SVH
`define VIC_DEFINES_SVH

`define VIC_OFS_ENABLE        12'h0a8
`define VIC_OFS_PRIORITY      12'h0b8
`define VIC_OFS_EXT_ENABLE    12'h0c0
`define VIC_OFS_EXT_PRIORITY  12'h0c4
`define VIC_OFS_PENDING       12'h0c8
`define VIC_OFS_STATUS        12'h0cc

`define VIC_GLOBAL_BIT        7
`define VIC_ENABLE_RESET      8'h00
`define VIC_PRIORITY_RESET    8'h80
`define VIC_EXT_RESET         16'h0000

`define VIC_VEC_BASE          16'h0003
`define VIC_VEC_STEP          16'h0008
`define VIC_VEC_RESET         16'h0000

`define VIC_DETECT_CYCLES     1
`define VIC_CALL_CYCLES       4
`define VIC_FAST_RESPONSE     5
`define VIC_SLOW_RESPONSE     18

`define VIC_LIN_CLEAR_BIT     3

`endif

// File: logic/vic_pkg.sv
// Purpose: types shared by the interrupt controller files
// Assumes: eighteen sources, order 0 highest within a level
// Notes:   constants live in vic_defines.svh
package vic_pkg;
  typedef logic [17:0] src_vec_t;
  typedef logic [4:0]  src_idx_t;
  typedef logic [15:0] vec_addr_t;
  typedef enum logic [2:0] {
    IDLE      = 3'b001,
    OFFER     = 3'b010,
    HOLD_NEXT = 3'b100
  } call_state_t;
endpackage

// File: logic/vic_source_merge.sv
// Purpose: folds the raw peripheral flags into one request line per source order
// Assumes: all flags arrive on the system clock; pins are synchronised by the caller
// Notes:   purely combinational, no flag is cleared here
module vic_source_merge (
  input  wire logic       extPend0,
  input  wire logic       timer0Flag,
  input  wire logic       extPend1,
  input  wire logic       timer1Flag,
  input  wire logic       uart_rx_done_flag,
  input  wire logic       uart_tx_done_flag,
  input  wire logic       timer2_low_overflow_flag,
  input  wire logic       timer2_high_overflow_flag,
  input  wire logic       serial_xfer_done_flag,
  input  wire logic       serial_write_collision_flag,
  input  wire logic       serial_mode_fault_flag,
  input  wire logic       serial_rx_overrun_flag,
  input  wire logic [6:0] sharedFlags,
  input  wire logic       counter_array_overflow_flag,
  input  wire logic [5:0] module_match_flag,
  input  wire logic       pwm_cycle_overflow_flag,
  input  wire logic       lin_request_flag,
  input  wire logic       regDropout,
  input  wire logic       can_request_flag,
  input  wire logic       portMatch,
  output vic_pkg::src_vec_t raw
);
  import vic_pkg::*;

  wire uartReq   = uart_rx_done_flag | uart_tx_done_flag;                    // see R14
  wire timer2Req = timer2_low_overflow_flag | timer2_high_overflow_flag;    // see R10
  wire serialReq = serial_xfer_done_flag | serial_write_collision_flag
                 | serial_mode_fault_flag | serial_rx_overrun_flag;         // see R11
  wire arrayReq  = counter_array_overflow_flag | (|module_match_flag)
                 | pwm_cycle_overflow_flag;                                 // see R12

  // shared flags: orders 7..9, then 11..13 around the array slot; shared flag bit 6 is unused
  assign raw = {portMatch, can_request_flag, regDropout, lin_request_flag, // see R21
                sharedFlags[5:3], arrayReq, sharedFlags[2:0],
                serialReq, timer2Req, uartReq, timer1Flag, extPend1, timer0Flag, extPend0};
endmodule

// File: logic/vic_arbiter.sv
// Purpose: picks the winning source among requests of one priority level
// Assumes: lowest order number wins
// Notes:   one instance per level; result is combinational
module vic_arbiter #(
  parameter int SOURCES = 18
) (
  input  wire logic [SOURCES-1:0] req,
  output logic                    any,
  output vic_pkg::src_idx_t       winner
);
  import vic_pkg::*;

  always_comb begin
    any    = 1'b0;
    winner = 5'h00;
    for (int i = SOURCES - 1; i >= 0; i--) begin
      if (req[i]) begin                    // see R7
        any    = 1'b1;
        winner = 5'(i);
      end
    end
  end
endmodule

// File: logic/vectored_interrupt_controller.sv
// Purpose: vectored two-level interrupt controller between peripheral flags and the cpu call logic
// Assumes: single 10 MHz system clock, apb register access, cpu marks instruction boundaries
// Notes:   the cpu performs the four-cycle call itself; this block offers vector and takes the ack
// Operation
// R1 - sample and resolve priority every clock
// R2 - best case: one detect, four call
// R3 - one instruction after return before call
// R4 - worst case eighteen clocks without competition
// R5 - equal or lower priority waits for return
// R6 - vectors 0x0003 stepping eight to 0x008B
// R7 - same level: lowest order number wins
// R8 - global enable bit 7 overrides masks
// R9 - enable bits 6..0 gate seven sources
// R10 - timer 2 merges low and high overflow
// R11 - serial merges four flags, none cleared
// R12 - counter array merges flags, left set
// R13 - software clears lin flag via control bit
// R14 - uart merges receive and transmit done
// R15 - external inputs gated by bits 0, 2
// R16 - high preempts low, high never preempted
// R17 - pending flags set regardless of enables
// R18 - hardware clears only ext, timer0/1, can
// R19 - flag left set re-enters after next instruction
// R20 - offer vector at boundary, ack records level
// R21 - flagless sources are level requests
//
// The APB register port was decided locally.
`include "vic_defines.svh"

module vectored_interrupt_controller #(
  parameter int SOURCES = 18
) (
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic                     pready,
  output logic [31:0]              prdata,
  output logic                     pslverr,
  // external input pins, edge detected here
  input  wire logic                ext_input_pin_0,
  input  wire logic                ext_input_pin_1,
  // peripheral pending flags, same clock
  input  wire logic                timer0Overflow,
  input  wire logic                timer1Overflow,
  input  wire logic                uart_rx_done_flag,
  input  wire logic                uart_tx_done_flag,
  input  wire logic                timer2_low_overflow_flag,
  input  wire logic                timer2_high_overflow_flag,
  input  wire logic                serial_xfer_done_flag,
  input  wire logic                serial_write_collision_flag,
  input  wire logic                serial_mode_fault_flag,
  input  wire logic                serial_rx_overrun_flag,
  input  wire logic [6:0]          sharedFlags,
  input  wire logic                counter_array_overflow_flag,
  input  wire logic [5:0]          module_match_flag,
  input  wire logic                pwm_cycle_overflow_flag,
  input  wire logic                lin_request_flag,
  input  wire logic                regDropout,
  input  wire logic                canEvent,
  input  wire logic                portMatch,
  // cpu side
  input  wire logic                instrDone,
  input  wire logic                callAck,
  input  wire logic                retiDone,
  output logic                     callReq,
  output vic_pkg::vec_addr_t       vectorAddr,
  output logic [4:0]               activeSource,
  output logic                     hwClear0,
  output logic                     hwClear1,
  output logic                     hwClearT0,
  output logic                     hwClearT1,
  output logic                     inHigh,
  output logic                     inLow
);
  import vic_pkg::*;

  // decoding reused for the winner's vector and for its clear strobe
  function automatic vec_addr_t vectorOf(input src_idx_t idx);
    vectorOf = 16'(`VIC_VEC_BASE + {11'h000, idx} * `VIC_VEC_STEP);  // see R6
  endfunction

  function automatic logic autoClears(input src_idx_t idx);
    autoClears = (idx == 5'h00) || (idx == 5'h01) || (idx == 5'h02)
              || (idx == 5'h03) || (idx == 5'h10);                    // see R18
  endfunction

  // registers
  logic [7:0]  interrupt_enable;
  logic [7:0]  interrupt_priority;
  logic [15:0] extEnable;
  logic [15:0] extPriority;

  // pin synchronisers and edge detect
  logic [1:0]  pin0Sync;
  logic [1:0]  pin1Sync;
  logic        pin0Last;
  logic        pin1Last;
  logic        extPend0;
  logic        extPend1;
  logic        canPend;

  // cpu handshake state
  call_state_t state;
  call_state_t next_state;
  logic        activeHigh;
  logic        activeLow;
  logic        holdLow;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pin0Sync <= 2'b11;
      pin1Sync <= 2'b11;
      pin0Last <= 1'b1;
      pin1Last <= 1'b1;
    end else begin
      pin0Sync <= {pin0Sync[0], ext_input_pin_0};
      pin1Sync <= {pin1Sync[0], ext_input_pin_1};
      pin0Last <= pin0Sync[1];
      pin1Last <= pin1Sync[1];
    end
  end

  // falling edge of an active-low pin marks a request
  wire pin0Fall = pin0Last & ~pin0Sync[1];
  wire pin1Fall = pin1Last & ~pin1Sync[1];

  src_vec_t raw;

  vic_source_merge u_merge (
    .extPend0                    (extPend0),
    .timer0Flag                  (timer0Overflow),
    .extPend1                    (extPend1),
    .timer1Flag                  (timer1Overflow),
    .uart_rx_done_flag           (uart_rx_done_flag),
    .uart_tx_done_flag           (uart_tx_done_flag),
    .timer2_low_overflow_flag    (timer2_low_overflow_flag),
    .timer2_high_overflow_flag   (timer2_high_overflow_flag),
    .serial_xfer_done_flag       (serial_xfer_done_flag),
    .serial_write_collision_flag (serial_write_collision_flag),
    .serial_mode_fault_flag      (serial_mode_fault_flag),
    .serial_rx_overrun_flag      (serial_rx_overrun_flag),
    .sharedFlags                 (sharedFlags),
    .counter_array_overflow_flag (counter_array_overflow_flag),
    .module_match_flag           (module_match_flag),
    .pwm_cycle_overflow_flag     (pwm_cycle_overflow_flag),
    .lin_request_flag            (lin_request_flag),              // see R13
    .regDropout                  (regDropout),
    .can_request_flag            (canPend),
    .portMatch                   (portMatch),
    .raw                         (raw)
  );

  // enable and priority masks per source order
  wire [SOURCES-1:0] srcEnable = {extEnable[10:0], interrupt_enable[6:0]};   // see R9 see R15
  wire [SOURCES-1:0] srcHigh   = {extPriority[10:0], interrupt_priority[6:0]};
  wire               globalOn  = interrupt_enable[`VIC_GLOBAL_BIT];          // see R8

  // pending stays independent of enable; masking only here
  wire [SOURCES-1:0] gated   = raw & srcEnable & {SOURCES{globalOn}};        // see R17
  wire [SOURCES-1:0] reqHigh = gated & srcHigh;
  wire [SOURCES-1:0] reqLow  = gated & ~srcHigh;

  logic     anyHigh;
  logic     anyLow;
  src_idx_t winHigh;
  src_idx_t winLow;

  vic_arbiter #(.SOURCES(SOURCES)) u_arb_high (
    .req    (reqHigh),
    .any    (anyHigh),
    .winner (winHigh)
  );

  vic_arbiter #(.SOURCES(SOURCES)) u_arb_low (
    .req    (reqLow),
    .any    (anyLow),
    .winner (winLow)
  );

  // high may preempt low; nothing preempts high; same level waits
  wire highAllowed = anyHigh & ~activeHigh;                                   // see R16 see R5
  wire lowAllowed  = anyLow & ~activeHigh & ~activeLow;                       // see R5
  wire eligible    = highAllowed | lowAllowed;
  wire pickHigh    = highAllowed;                                             // see R16
  src_idx_t pick;
  assign pick = pickHigh ? winHigh : winLow;

  always_comb begin
    next_state = state;
    unique case (state)
      IDLE: begin
        // resolved every clock; offer lands at the next boundary
        if (eligible && instrDone) begin                                      // see R1 see R2
          next_state = OFFER;
        end
      end
      OFFER: begin
        if (callAck) begin                                                    // see R20
          next_state = IDLE;
        end
      end
      HOLD_NEXT: begin
        if (instrDone) begin                                                  // see R3 see R4
          // call goes out at the boundary of the one instruction after return
          next_state = eligible ? OFFER : IDLE;                               // see R19
        end
      end
    endcase
    if (retiDone) begin
      next_state = HOLD_NEXT;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state        <= IDLE;
      callReq      <= 1'b0;
      vectorAddr   <= `VIC_VEC_RESET;
      activeSource <= 5'h00;
    end else begin
      state   <= next_state;
      callReq <= (next_state == OFFER);
      // vector frozen while the offer stands so the cpu sees a stable address
      if (state != OFFER) begin
        vectorAddr   <= vectorOf(pick);                                       // see R6
        activeSource <= pick;
      end
    end
  end

  // records the level on acknowledge, one level popped per return
  wire offerHigh = srcHigh[activeSource];
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      activeHigh <= 1'b0;
      activeLow  <= 1'b0;
      holdLow    <= 1'b0;
    end else if (state == OFFER && callAck) begin                             // see R20
      if (offerHigh) begin
        activeHigh <= 1'b1;
        holdLow    <= activeLow;
      end else begin
        activeLow  <= 1'b1;
      end
    end else if (retiDone) begin
      if (activeHigh) begin
        activeHigh <= 1'b0;
        activeLow  <= holdLow;
      end else begin
        activeLow  <= 1'b0;
      end
    end
  end

  // clear strobes on vectoring for the self-clearing sources only
  wire ackNow   = (state == OFFER) && callAck;
  wire clearHit = ackNow && autoClears(activeSource);                         // see R18
  wire clr0     = clearHit && (activeSource == 5'h00);
  wire clr1     = clearHit && (activeSource == 5'h02);
  wire clrCan   = clearHit && (activeSource == 5'h10);

  // new edge wins over a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      extPend0  <= 1'b0;
      extPend1  <= 1'b0;
      canPend   <= 1'b0;
      hwClear0  <= 1'b0;
      hwClear1  <= 1'b0;
      hwClearT0 <= 1'b0;
      hwClearT1 <= 1'b0;
    end else begin
      extPend0  <= pin0Fall | (extPend0 & ~clr0);
      extPend1  <= pin1Fall | (extPend1 & ~clr1);
      canPend   <= canEvent | (canPend & ~clrCan);
      hwClear0  <= clr0;
      hwClear1  <= clr1;
      hwClearT0 <= clearHit && (activeSource == 5'h01);
      hwClearT1 <= clearHit && (activeSource == 5'h03);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      inHigh <= 1'b0;
      inLow  <= 1'b0;
    end else begin
      inHigh <= activeHigh;
      inLow  <= activeLow;
    end
  end

  // apb: zero wait states, unmapped offsets answer with slverr
  wire setup    = psel & ~penable;
  wire access   = psel & penable;
  wire hitEn    = paddr == `VIC_OFS_ENABLE;
  wire hitPri   = paddr == `VIC_OFS_PRIORITY;
  wire hitXEn   = paddr == `VIC_OFS_EXT_ENABLE;
  wire hitXPri  = paddr == `VIC_OFS_EXT_PRIORITY;
  wire hitPend  = paddr == `VIC_OFS_PENDING;
  wire hitStat  = paddr == `VIC_OFS_STATUS;
  wire mapped   = hitEn | hitPri | hitXEn | hitXPri | hitPend | hitStat;
  wire wrStrobe = access & pwrite & pready;

  wire [31:0] statusWord = {11'h000, activeSource, 8'h00, 3'b000, activeHigh, activeLow, state};
  wire [31:0] readMux =
      hitEn   ? {24'h00_0000, interrupt_enable} :
      hitPri  ? {24'h00_0000, interrupt_priority} :
      hitXEn  ? {16'h0000, extEnable} :
      hitXPri ? {16'h0000, extPriority} :
      hitPend ? {14'h0000, raw} :
      hitStat ? statusWord : 32'h0000_0000;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      prdata  <= (setup & ~pwrite) ? readMux : 32'h0000_0000;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      interrupt_enable   <= `VIC_ENABLE_RESET;
      interrupt_priority <= `VIC_PRIORITY_RESET;
      extEnable          <= `VIC_EXT_RESET;
      extPriority        <= `VIC_EXT_RESET;
    end else if (wrStrobe) begin
      if (hitEn) begin
        interrupt_enable <= pwdata[7:0];                                      // see R8 see R9
      end
      if (hitPri) begin
        // top bit reads as one and ignores writes
        interrupt_priority <= {1'b1, pwdata[6:0]};
      end
      if (hitXEn) begin
        extEnable <= {5'h00, pwdata[10:0]};
      end
      if (hitXPri) begin
        extPriority <= {5'h00, pwdata[10:0]};
      end
    end
  end
endmodule

// File: verif/vic_properties.sv
// Purpose: port-level checks for the vectored interrupt controller
// Assumes: one clock, synchronous active-low reset
// Notes:   enable shadow follows completed apb writes
module vic_properties
  import vic_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        instrDone,
  input wire logic        callAck,
  input wire logic        retiDone,
  input wire logic        callReq,
  input wire vec_addr_t   vectorAddr,
  input wire logic [4:0]  activeSource,
  input wire logic        hwClear0,
  input wire logic        hwClear1,
  input wire logic        hwClearT0,
  input wire logic        hwClearT1,
  input wire logic        inHigh
);
  timeunit 1ns;
  timeprecision 1ns;
  logic globalOn;
  logic holdNext;
  logic enWrite;
  assign enWrite = psel && penable && pwrite && pready && (paddr == 12'h0a8);
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      globalOn <= 1'b0;
      holdNext <= 1'b0;
    end else begin
      if (enWrite) globalOn <= pwdata[7];
      if (retiDone) holdNext <= 1'b1;
      else if (instrDone) holdNext <= 1'b0;
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  offer_hold_a: assert property (callReq && !callAck |=> callReq)
    else $error("offer dropped early");
  vector_steady_a: assert property (callReq && !callAck |=> $stable(vectorAddr) && $stable(activeSource))
    else $error("vector moved during offer");
  vector_map_a: assert property (callReq |-> activeSource <= 5'd17 && vectorAddr == 16'h0003 + {8'h00, activeSource, 3'b000})
    else $error("vector does not match order");
  clear_ext_a: assert property (hwClear0 == $past(callReq && callAck && activeSource == 5'd0)
    && hwClear1 == $past(callReq && callAck && activeSource == 5'd2)) else $error("external clear wrong");
  clear_timer_a: assert property (hwClearT0 == $past(callReq && callAck && activeSource == 5'd1)
    && hwClearT1 == $past(callReq && callAck && activeSource == 5'd3)) else $error("timer clear wrong");
  high_no_preempt_a: assert property (inHigh |-> !callReq)
    else $error("high handler preempted");
  return_hold_a: assert property (holdNext |-> !callReq)
    else $error("offer before next instruction");
  global_gate_a: assert property ($rose(callReq) |-> $past(globalOn))
    else $error("offer with global enable off");
endmodule

bind vectored_interrupt_controller vic_properties u_props (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .instrDone(instrDone),
  .callAck(callAck), .retiDone(retiDone), .callReq(callReq), .vectorAddr(vectorAddr), .activeSource(activeSource),
  .hwClear0(hwClear0), .hwClear1(hwClear1), .hwClearT0(hwClearT0), .hwClearT1(hwClearT1), .inHigh(inHigh));

// File: verif/cpu_sequencer_model.sv
// Purpose: cpu instruction sequencer facing the controller
// Assumes: instrLen cycles per instruction, call takes four cycles
// Notes:   no boundaries are marked while a call is running
module cpu_sequencer_model (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       callReq,
  input  wire logic [3:0] instrLen,
  input  wire logic       doReti,
  output logic            instrDone,
  output logic            callAck,
  output logic            retiDone
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] instrCnt;
  logic [1:0] callCnt;
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      instrDone <= 1'b0;
      callAck   <= 1'b0;
      retiDone  <= 1'b0;
      instrCnt  <= 4'h0;
      callCnt   <= 2'd0;
    end else begin
      callAck  <= callReq && !callAck && callCnt == 2'd2;
      callCnt  <= (callReq && !callAck) ? callCnt + 2'd1 : 2'd0;
      retiDone <= doReti;
      if (doReti || callReq || callAck) begin
        instrDone <= 1'b0;
        instrCnt  <= 4'h0;
      end else begin
        instrDone <= instrCnt == instrLen - 4'h1;
        instrCnt  <= (instrCnt == instrLen - 4'h1) ? 4'h0 : instrCnt + 4'h1;
      end
    end
  end
endmodule

// File: verif/test_vectored_interrupt_controller.sv
// Purpose: self-checking bench for the vectored interrupt controller
// Assumes: cpu model acks four cycles into an offer
// Notes:   bench clears timer flags on the hardware clear pulses
module test_vectored_interrupt_controller;
  timeunit 1ns;
  timeprecision 1ns;
  import vic_pkg::*;
  localparam int LIM = 15;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        pin0 = 1'b1;
  logic        pin1 = 1'b1;
  logic [27:0] flags = 28'h000_0000;
  logic        canEvent = 1'b0;
  logic [3:0]  instrLen = 4'h1;
  logic        doReti = 1'b0;
  logic        pready, pslverr, instrDone, callAck, retiDone, callReq, inHigh, inLow;
  logic        hwClear0, hwClear1, hwClearT0, hwClearT1;
  logic [31:0] prdata;
  logic [4:0]  activeSource;
  vec_addr_t   vectorAddr;
  logic [31:0] rd;
  logic        er;
  int          n;
  int          err_total = 0;
  int          check_count = 0;
  int          rows[23][2] = '{'{0, 1}, '{1, 3}, '{2, 4}, '{3, 4}, '{4, 5}, '{5, 5}, '{6, 6}, '{7, 6}, '{8, 6},
    '{9, 6}, '{10, 7}, '{11, 8}, '{12, 9}, '{17, 10}, '{18, 10}, '{23, 10}, '{24, 10}, '{13, 11}, '{14, 12},
    '{15, 13}, '{25, 14}, '{26, 15}, '{27, 17}};
  int          maskBit[5] = '{1, 3, 4, 5, 6};
  int          maskFlag[5] = '{0, 1, 2, 4, 6};
  int          extOrder[3] = '{0, 2, 16};

  vectored_interrupt_controller DUT (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .ext_input_pin_0(pin0), .ext_input_pin_1(pin1), .timer0Overflow(flags[0]), .timer1Overflow(flags[1]),
    .uart_rx_done_flag(flags[2]), .uart_tx_done_flag(flags[3]), .timer2_low_overflow_flag(flags[4]),
    .timer2_high_overflow_flag(flags[5]), .serial_xfer_done_flag(flags[6]), .serial_write_collision_flag(flags[7]),
    .serial_mode_fault_flag(flags[8]), .serial_rx_overrun_flag(flags[9]), .sharedFlags(flags[16:10]),
    .counter_array_overflow_flag(flags[17]), .module_match_flag(flags[23:18]), .pwm_cycle_overflow_flag(flags[24]),
    .lin_request_flag(flags[25]), .regDropout(flags[26]), .canEvent(canEvent), .portMatch(flags[27]),
    .instrDone(instrDone), .callAck(callAck), .retiDone(retiDone), .callReq(callReq), .vectorAddr(vectorAddr),
    .activeSource(activeSource), .hwClear0(hwClear0), .hwClear1(hwClear1), .hwClearT0(hwClearT0),
    .hwClearT1(hwClearT1), .inHigh(inHigh), .inLow(inLow));
  cpu_sequencer_model cpu (.ref_clk(ref_clk), .rst_n(rst_n), .callReq(callReq), .instrLen(instrLen),
    .doReti(doReti), .instrDone(instrDone), .callAck(callAck), .retiDone(retiDone));

  always #50 ref_clk = ~ref_clk;
  // peripheral side drops its own flag on the clear pulse
  always @(posedge ref_clk) begin
    if (hwClearT0) flags[0] <= 1'b0;
    if (hwClearT1) flags[1] <= 1'b0;
  end

  task automatic chk(input bit ok, input string msg);
    check_count++;
    if (!ok) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic waitFor(input logic lvl);
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (callReq !== lvl && n < LIM);
  endtask
  task automatic setFlag(input int b, input logic v);
    @(posedge ref_clk);
    flags[b] <= v;
  endtask
  task automatic handler_return_instr;
    @(posedge ref_clk);
    doReti <= 1'b1;
    @(posedge ref_clk);
    doReti <= 1'b0;
  endtask
  task automatic end_of_test;
    if (err_total == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge ref_clk);
    err_total++;
    end_of_test;
  end

  initial begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    apb(1'b1, 12'h0a8, 32'h0000_00ff);
    apb(1'b1, 12'h0c0, 32'h0000_07ff);
    foreach (rows[i]) begin
      setFlag(rows[i][0], 1'b1);
      @(negedge ref_clk);
      @(negedge ref_clk);
      chk(callReq === 1'b1, "late offer");
      chk(activeSource === 5'(rows[i][1]), "wrong source");
      chk(vectorAddr === 16'(3 + 8 * rows[i][1]), "wrong vector");
      waitFor(1'b0);
      setFlag(rows[i][0], 1'b0);
      handler_return_instr;
      repeat (3) @(posedge ref_clk);
    end
    // second reset in mid-run, then reset values
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    apb(1'b0, 12'h0a8, 32'h0000_0000);
    chk(rd === 32'h0000_0000 && er === 1'b0, "enable reset value");
    apb(1'b0, 12'h0b8, 32'h0000_0000);
    chk(rd === 32'h0000_0080, "priority reset value");
    apb(1'b1, 12'h004, 32'hffff_ffff);
    chk(er === 1'b1, "unmapped write accepted");
    apb(1'b1, 12'h0a8, 32'h0000_007f);
    apb(1'b0, 12'h0a8, 32'h0000_0000);
    chk(rd === 32'h0000_007f, "enable readback");
    setFlag(0, 1'b1);
    waitFor(1'b1);
    chk(callReq === 1'b0, "offer with global off");
    setFlag(0, 1'b0);
    foreach (maskBit[k]) begin
      apb(1'b1, 12'h0a8, 32'h0000_0080 | (32'h0000_007f & ~(32'h0000_0001 << maskBit[k])));
      setFlag(maskFlag[k], 1'b1);
      waitFor(1'b1);
      chk(callReq === 1'b0, "masked source offered");
      apb(1'b0, 12'h0c8, 32'h0000_0000);
      chk(rd[maskBit[k]] === 1'b1, "pending hidden");
      setFlag(maskFlag[k], 1'b0);
    end
    // same level ties, then high preempts low
    apb(1'b1, 12'h0a8, 32'h0000_00ff);
    apb(1'b1, 12'h0b8, 32'h0000_0010);
    @(posedge ref_clk);
    flags[1] <= 1'b1;
    flags[4] <= 1'b1;
    waitFor(1'b1);
    chk(activeSource === 5'd3, "tie not to lowest order");
    waitFor(1'b0);
    waitFor(1'b1);
    chk(callReq === 1'b0, "equal level preempted");
    setFlag(2, 1'b1);
    waitFor(1'b1);
    chk(callReq === 1'b1 && activeSource === 5'd4 && inLow === 1'b1, "high did not preempt");
    waitFor(1'b0);
    @(negedge ref_clk);
    chk(inHigh === 1'b1, "high level not recorded");
    setFlag(2, 1'b0);
    handler_return_instr;
    waitFor(1'b1);
    chk(callReq === 1'b0, "low level preempted low");
    handler_return_instr;
    waitFor(1'b1);
    chk(activeSource === 5'd5, "held request lost");
    waitFor(1'b0);
    setFlag(4, 1'b0);
    handler_return_instr;
    // flag left set across a return, divide after it
    setFlag(2, 1'b1);
    waitFor(1'b1);
    waitFor(1'b0);
    instrLen <= 4'h8;
    handler_return_instr;
    waitFor(1'b1);
    chk(n === 10 && activeSource === 5'd4, "re-entry timing");
    waitFor(1'b0);
    setFlag(2, 1'b0);
    instrLen <= 4'h1;
    handler_return_instr;
    apb(1'b1, 12'h0b8, 32'h0000_0000);
    apb(1'b1, 12'h0c0, 32'h0000_07ff);
    foreach (extOrder[k]) begin
      @(posedge ref_clk);
      pin0 <= (k != 0);
      pin1 <= (k != 1);
      canEvent <= (k == 2);
      @(posedge ref_clk);
      canEvent <= 1'b0;
      waitFor(1'b1);
      chk(activeSource === 5'(extOrder[k]), "event source wrong");
      waitFor(1'b0);
      @(posedge ref_clk);
      pin0 <= 1'b1;
      pin1 <= 1'b1;
      handler_return_instr;
      waitFor(1'b1);
      chk(callReq === 1'b0, "event not cleared");
    end
    end_of_test;
  end
endmodule
